// ---- bench/oh_partner.sv ----
// Far-side overhead source model for the auxiliary and ring ports
module oh_partner
  import chan_evt_pkg::*;
(
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic [3:0] cmd_lanes,
  input wire logic cmd_ring,
  input wire logic [31:0] cmd_word,
  input wire logic [3:0] cmd_v5,
  // Port lines
  output oh_bytes_t aux_in,
  output logic [3:0] aux_valid,
  output v5_bits_t ring_in,
  output logic ring_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] aux_last = 32'h0;
  logic [3:0] ring_last = 4'h0;
  initial begin
    aux_in = '1;
    aux_valid = 4'h0;
    ring_in = '1;
    ring_valid = 1'b0;
  end
  // Idle lines carry the inverse of the last byte, so a stale copy cannot pass
  always @(posedge clk) begin
    aux_valid <= cmd_lanes;
    ring_valid <= cmd_ring;
    aux_in <= (|cmd_lanes) ? cmd_word : ~aux_last;
    ring_in <= cmd_ring ? cmd_v5 : ~ring_last;
    if (|cmd_lanes) aux_last <= cmd_word;
    if (cmd_ring) ring_last <= cmd_v5;
  end
endmodule : oh_partner

// ---- bench/tb.sv ----
// Self-checking bench for the channel event mask and port select block
`include "chan_evt_params.svh"
module tb
  import chan_evt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h1, aux_valid, cmd_lanes = 4'h0, cmd_v5 = 4'h0;
  logic [1:0] bresp, rresp;
  logic ring_valid, cmd_ring = 1'b0;
  logic [31:0] cmd_word = 32'h0;
  evt_vec_t status_in = {8'h3c, 8'hc3, 3'h5}, event_in = '0;
  oh_bytes_t aux_in, aux_out;
  v5_bits_t ring_in, v5_out, local_v5 = 4'he;
  int n_fail = 0, check_count = 0;
  typedef struct packed {
    logic [5:0] idx; logic [7:0] wd; logic [1:0] wr; logic [7:0] rd; logic [1:0] rr;
  } row_t;
  row_t rows [7] = '{
    '{`IDX_ALARM_MASK, 8'ha5, `RESP_OKAY, 8'ha5, `RESP_OKAY},
    '{`IDX_PATH_MASK, 8'h06, `RESP_OKAY, 8'h06, `RESP_OKAY},
    '{`IDX_RDI_MASK, 8'h05, `RESP_OKAY, 8'h05, `RESP_OKAY},
    '{`IDX_PORT_SEL, 8'h00, `RESP_OKAY, 8'h00, `RESP_OKAY},
    '{`IDX_ALARM_STAT, 8'h00, `RESP_SLVERR, 8'h3c, `RESP_OKAY},
    '{`IDX_RING, 8'h00, `RESP_SLVERR, 8'h00, `RESP_OKAY},
    '{6'h3f, 8'h00, `RESP_SLVERR, 8'h00, `RESP_SLVERR}};
  always #5 clk = ~clk;
  channel_event_mask_port_select u_dut (.clk(clk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .status_in(status_in), .event_in(event_in), .irq(irq),
    .aux_in(aux_in), .aux_valid(aux_valid), .ring_in(ring_in), .ring_valid(ring_valid),
    .aux_out(aux_out), .local_v5(local_v5), .v5_out(v5_out));
  oh_partner u_far (.clk(clk), .cmd_lanes(cmd_lanes), .cmd_ring(cmd_ring),
    .cmd_word(cmd_word), .cmd_v5(cmd_v5), .aux_in(aux_in), .aux_valid(aux_valid),
    .ring_in(ring_in), .ring_valid(ring_valid));
  // ----
  // Checking and bus tasks
  // ----
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // Ready is read mid-cycle, where it is settled, and acted on at the next edge
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic ha, hw, hb, done;
    logic [1:0] resp;
    done = 1'b0;
    resp = 2'h3;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      if (hb) resp = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      done = hb;
    end
    // One idle edge, so registered outputs settle and no strobe is driven twice in a step
    @(posedge clk);
    cmp("bresp", {30'h0, er}, {30'h0, resp});
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic ha, hr, done;
    logic [31:0] d;
    logic [1:0] resp;
    done = 1'b0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      done = hr;
    end
    @(posedge clk);
    cmp("rdata", {24'h0, e}, d);
    cmp("rresp", {30'h0, er}, {30'h0, resp});
  endtask : rd
  task automatic send(input logic [3:0] ln, input logic rg, input logic [31:0] w);
    cmd_lanes <= ln;
    cmd_ring <= rg;
    cmd_word <= w;
    cmd_v5 <= 4'hb;
    @(posedge clk);
    cmd_lanes <= 4'h0;
    cmd_ring <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : send
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, rows[i].wr);
      rd(rows[i].idx, rows[i].rd, rows[i].rr);
    end
    // Masked event still latches; unmasked one drives the interrupt
    wr(`IDX_ALARM_MASK, 8'h80, `RESP_OKAY);
    wr(`IDX_RDI_MASK, 8'h04, `RESP_OKAY);
    event_in <= {8'h81, 8'h00, 3'h4};
    @(posedge clk);
    event_in <= '0;
    repeat (2) @(posedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(`IDX_ALARM_EVT, 8'h81, `RESP_OKAY);
    wr(`IDX_ALARM_EVT, 8'h01, `RESP_OKAY);
    cmp("irq", 32'h0, {31'h0, irq});
    rd(`IDX_ALARM_EVT, 8'h80, `RESP_OKAY);
    rd(`IDX_RDI_EVT, 8'h04, `RESP_OKAY);
    wr(`IDX_RDI_MASK, 8'h00, `RESP_OKAY);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(`IDX_RDI_EVT, 8'h04, `RESP_OKAY);
    cmp("irq", 32'h0, {31'h0, irq});
    // Aux capture, then register source with port traffic ignored
    wr(`IDX_PORT_SEL, 8'h0f, `RESP_OKAY);
    send(4'hf, 1'b0, 32'hc1d2e3f4);
    cmp("aux_out", 32'hc1d2e3f4, aux_out);
    for (int i = 0; i < 4; i++) rd(6'(`IDX_OBIT + i), 8'hc1 + 8'(i * 17), `RESP_OKAY);
    wr(`IDX_PORT_SEL, 8'h00, `RESP_OKAY);
    wr(`IDX_TRACE, 8'h77, `RESP_OKAY);
    send(4'hf, 1'b0, 32'h11223344);
    cmp("aux_out", 32'hc177e3f4, aux_out);
    // Ring wins over aps byte; aps byte alone replaces rdi bits
    wr(`IDX_PORT_SEL, 8'h11, `RESP_OKAY);
    send(4'h0, 1'b1, 32'h0);
    cmp("v5_out", 32'hb, {28'h0, v5_out});
    rd(`IDX_RING, 8'h0b, `RESP_OKAY);
    wr(`IDX_PORT_SEL, 8'h01, `RESP_OKAY);
    cmp("v5_out", 32'ha, {28'h0, v5_out});
    wr(`IDX_PORT_SEL, 8'h00, `RESP_OKAY);
    cmp("v5_out", 32'he, {28'h0, v5_out});
    // Second reset in mid-run clears everything
    wr(`IDX_PATH_MASK, 8'hff, `RESP_OKAY);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    cmp("aux_out", 32'h0, aux_out);
    cmp("v5_out", 32'h0, {28'h0, v5_out});
    cmp("irq", 32'h0, {31'h0, irq});
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("v5_out", 32'he, {28'h0, v5_out});
    rd(`IDX_ALARM_EVT, 8'h00, `RESP_OKAY);
    for (int i = 8; i < 12; i++) rd(6'(i), 8'h00, `RESP_OKAY);
    tally_and_finish();
  end
endmodule : tb

// ---- core/chan_evt_params.svh ----
// Register indices, field positions, reset values and notes for the channel event block
//
// Notes on behaviour
// - Masks gate interrupts only; events still latch
// - Alarm mask: pin, demap, LOS, map, AIS, ptr, gen, CV
// - Path mask: REI, BIP-2, VT AIS, LOP, RFI, UNEQ, SLM, RDI
// - RDI mask: bit2 payload, bit1 server, bit0 connectivity
// - Ring enable sources V5 REI/RDI; ring data readable
// - O-bit aux enable: capture port bytes, else register
// - J2 aux enable: capture port byte, else register
// - Z6/N2 aux enable: capture port byte, else register
// - Z7/K4 aux enable: capture port byte, else register
// - Ring enable wins over Z7/K4 for RDI
`ifndef CHAN_EVT_PARAMS_SVH
`define CHAN_EVT_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_ALARM_MASK 6'h08
`define IDX_PATH_MASK 6'h09
`define IDX_RDI_MASK 6'h0a
`define IDX_PORT_SEL 6'h0b
`define IDX_ALARM_STAT 6'h10
`define IDX_PATH_STAT 6'h11
`define IDX_RDI_STAT 6'h12
`define IDX_ALARM_EVT 6'h18
`define IDX_PATH_EVT 6'h19
`define IDX_RDI_EVT 6'h1a
`define IDX_OBIT 6'h36
`define IDX_TRACE 6'h37
`define IDX_TANDEM 6'h38
`define IDX_APS 6'h39
`define IDX_RING 6'h3a

// ----------------------------------------------------------------
// Port select fields and register field widths
// ----------------------------------------------------------------
`define SEL_RING 4
`define SEL_OBIT 3
`define SEL_TRACE 2
`define SEL_TANDEM 1
`define SEL_APS 0
`define RDI_MASK_W 3
`define PORT_SEL_W 5

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define RST_MASK8 8'h00
`define RST_MASK3 3'h0
`define RST_PORT_SEL 5'h00
`define RST_BYTE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- core/chan_evt_pkg.sv ----
// Types shared by the channel event mask and port select block
package chan_evt_pkg;

  typedef struct packed {
    logic [7:0] alarm;
    logic [7:0] path;
    logic [2:0] rdi;
  } evt_vec_t;

  typedef struct packed {
    logic [7:0] obit;
    logic [7:0] trace;
    logic [7:0] tandem;
    logic [7:0] aps;
  } oh_bytes_t;

  typedef struct packed {
    logic rei;
    logic [2:0] rdi;
  } v5_bits_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

endpackage : chan_evt_pkg

// ---- core/channel_event_mask_port_select.sv ----
// Per-channel event masking, interrupt and overhead port source selection
`include "chan_evt_params.svh"

module channel_event_mask_port_select
  import chan_evt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Detector side
  input wire evt_vec_t status_in,
  input wire evt_vec_t event_in,
  output logic irq,
  // Auxiliary and ring ports
  input wire oh_bytes_t aux_in,
  input wire logic [3:0] aux_valid,
  input wire v5_bits_t ring_in,
  input wire logic ring_valid,
  output oh_bytes_t aux_out,
  // V5 insertion
  input wire v5_bits_t local_v5,
  output v5_bits_t v5_out
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[7:2];
  endfunction : reg_index

  evt_vec_t mask_reg, mask_next;
  evt_vec_t evt_reg, evt_next;
  logic [`PORT_SEL_W-1:0] sel_reg, sel_next;
  oh_bytes_t oh_reg, oh_next;
  v5_bits_t ring_reg, ring_next;
  v5_bits_t v5_reg, v5_next;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  wr_state_t wr_state_reg, wr_state_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next;
  logic wr_fire;
  logic [5:0] widx;
  logic [7:0] wbyte;

  assign awready = (wr_state_reg == WR_IDLE) && !aw_have_reg;
  assign wready = (wr_state_reg == WR_IDLE) && !w_have_reg;
  assign bvalid = (wr_state_reg == WR_RESP);
  assign bresp = bresp_reg;
  assign wr_fire = (wr_state_reg == WR_IDLE) && aw_have_reg && w_have_reg;
  assign widx = reg_index(waddr_reg);
  assign wbyte = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    if (awvalid && awready) begin
      aw_have_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_have_next = 1'b1;
      wdata_next = wdata;
      wstrb_next = wstrb;
    end
    case (wr_state_reg)
      WR_IDLE: begin
        if (wr_fire) begin
          wr_state_next = WR_RESP;
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          bresp_next = reg_read(widx, 1'b1) ? `RESP_OKAY : `RESP_SLVERR;
        end
      end
      WR_RESP: begin
        if (bready) begin
          wr_state_next = WR_IDLE;
        end
      end
      default: begin
        wr_state_next = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_state_reg <= WR_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Returns mapped flag; for writes only writable registers count
  function automatic logic reg_read(input logic [5:0] idx, input logic for_write);
    case (idx)
      `IDX_ALARM_MASK, `IDX_PATH_MASK, `IDX_RDI_MASK, `IDX_PORT_SEL,
      `IDX_ALARM_EVT, `IDX_PATH_EVT, `IDX_RDI_EVT,
      `IDX_OBIT, `IDX_TRACE, `IDX_TANDEM, `IDX_APS: reg_read = 1'b1;
      `IDX_ALARM_STAT, `IDX_PATH_STAT, `IDX_RDI_STAT, `IDX_RING: reg_read = !for_write;
      default: reg_read = 1'b0;
    endcase
  endfunction : reg_read

  always_comb begin
    mask_next = mask_reg;
    sel_next = sel_reg;
    oh_next = oh_reg;
    ring_next = ring_reg;
    evt_next = evt_reg;
    if (wr_fire) begin
      case (widx)
        `IDX_ALARM_MASK: mask_next.alarm = wbyte;
        `IDX_PATH_MASK: mask_next.path = wbyte;
        `IDX_RDI_MASK: mask_next.rdi = wbyte[`RDI_MASK_W-1:0];
        `IDX_PORT_SEL: sel_next = wbyte[`PORT_SEL_W-1:0];
        `IDX_ALARM_EVT: evt_next.alarm = evt_reg.alarm & ~wbyte;
        `IDX_PATH_EVT: evt_next.path = evt_reg.path & ~wbyte;
        `IDX_RDI_EVT: evt_next.rdi = evt_reg.rdi & ~wbyte[2:0];
        `IDX_OBIT: oh_next.obit = wbyte;
        `IDX_TRACE: oh_next.trace = wbyte;
        `IDX_TANDEM: oh_next.tandem = wbyte;
        `IDX_APS: oh_next.aps = wbyte;
        default: begin
        end
      endcase
    end
    // New events win over a same-cycle clear; masks never stop latching
    evt_next = evt_next | event_in;
    // Port capture overrides a software write in the same cycle
    if (sel_reg[`SEL_OBIT] && aux_valid[3]) begin
      oh_next.obit = aux_in.obit;
    end
    if (sel_reg[`SEL_TRACE] && aux_valid[2]) begin
      oh_next.trace = aux_in.trace;
    end
    if (sel_reg[`SEL_TANDEM] && aux_valid[1]) begin
      oh_next.tandem = aux_in.tandem;
    end
    if (sel_reg[`SEL_APS] && aux_valid[0]) begin
      oh_next.aps = aux_in.aps;
    end
    // Ring data is kept readable whether or not it is selected
    if (ring_valid) begin
      ring_next = ring_in;
    end
    v5_next = local_v5;
    if (sel_reg[`SEL_RING]) begin
      v5_next = ring_reg;
    end else if (sel_reg[`SEL_APS]) begin
      v5_next.rdi = oh_reg.aps[3:1];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg <= {`RST_MASK8, `RST_MASK8, `RST_MASK3};
      evt_reg <= '0;
      sel_reg <= `RST_PORT_SEL;
      oh_reg <= {4{`RST_BYTE}};
      ring_reg <= '0;
      v5_reg <= '0;
    end else begin
      mask_reg <= mask_next;
      evt_reg <= evt_next;
      sel_reg <= sel_next;
      oh_reg <= oh_next;
      ring_reg <= ring_next;
      v5_reg <= v5_next;
    end
  end

  assign aux_out = oh_reg;
  assign v5_out = v5_reg;
  assign irq = |(evt_reg & ~mask_reg);

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [5:0] ridx;
  logic [7:0] rbyte;

  assign arready = !rvalid_reg;
  assign ridx = reg_index(araddr);

  always_comb begin
    case (ridx)
      `IDX_ALARM_MASK: rbyte = mask_reg.alarm;
      `IDX_PATH_MASK: rbyte = mask_reg.path;
      `IDX_RDI_MASK: rbyte = {5'h00, mask_reg.rdi};
      `IDX_PORT_SEL: rbyte = {3'h0, sel_reg};
      `IDX_ALARM_STAT: rbyte = status_in.alarm;
      `IDX_PATH_STAT: rbyte = status_in.path;
      `IDX_RDI_STAT: rbyte = {5'h00, status_in.rdi};
      `IDX_ALARM_EVT: rbyte = evt_reg.alarm;
      `IDX_PATH_EVT: rbyte = evt_reg.path;
      `IDX_RDI_EVT: rbyte = {5'h00, evt_reg.rdi};
      `IDX_OBIT: rbyte = oh_reg.obit;
      `IDX_TRACE: rbyte = oh_reg.trace;
      `IDX_TANDEM: rbyte = oh_reg.tandem;
      `IDX_APS: rbyte = oh_reg.aps;
      `IDX_RING: rbyte = {4'h0, ring_reg};
      default: rbyte = 8'h00;
    endcase
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rbyte};
      rresp_next = reg_read(ridx, 1'b0) ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_ring_take;
    (sel_reg[`SEL_RING] && ring_valid) ##1 (sel_reg[`SEL_RING] && !ring_valid);
  endsequence

  sequence s_ring_drive;
    ##1 (v5_out == $past(ring_in, 2));
  endsequence

  a_event_latches_masked: assert property ((event_in.alarm[7] && mask_reg.alarm[7])
      |=> evt_reg.alarm[7]) else $error("masked event not latched");
  a_irq_follows_event: assert property (((event_in & ~mask_next) != '0)
      |=> irq) else $error("unmasked event gave no interrupt");
  a_irq_quiet_masked: assert property ($rose(irq)
      |-> $past(((evt_reg | event_in) & ~mask_next) != '0))
      else $error("interrupt without unmasked event");
  a_ring_drives_v5: assert property (s_ring_take |-> s_ring_drive)
      else $error("ring value not on V5");
  a_ring_over_aps: assert property ((sel_reg[`SEL_RING] && sel_reg[`SEL_APS])
      |=> v5_out.rdi == $past(ring_reg.rdi)) else $error("aps port beat ring");
  a_obit_capture: assert property ((sel_reg[`SEL_OBIT] && aux_valid[3])
      |=> aux_out.obit == $past(aux_in.obit)) else $error("O-bit not captured");
  a_trace_capture: assert property ((sel_reg[`SEL_TRACE] && aux_valid[2])
      |=> aux_out.trace == $past(aux_in.trace)) else $error("J2 not captured");
  a_tandem_capture: assert property ((sel_reg[`SEL_TANDEM] && aux_valid[1])
      |=> aux_out.tandem == $past(aux_in.tandem)) else $error("Z6 not captured");
  a_aps_capture: assert property ((sel_reg[`SEL_APS] && aux_valid[0])
      |=> aux_out.aps == $past(aux_in.aps)) else $error("Z7 not captured");
  a_local_v5: assert property ((!sel_reg[`SEL_RING] && !sel_reg[`SEL_APS])
      |=> v5_out == $past(local_v5)) else $error("local V5 not passed");
  a_bvalid_holds: assert property ((bvalid && !bready) |=> bvalid)
      else $error("write response dropped");
  a_rdi_mask_write: assert property ((wr_fire && widx == `IDX_RDI_MASK)
      |=> mask_reg.rdi == $past(wbyte[2:0])) else $error("RDI mask not written");

endmodule : channel_event_mask_port_select
